// ==== include/fp_status_defs.svh ====
// Field positions, reset values and codes of the status block
`ifndef FP_STATUS_DEFS_SVH
`define FP_STATUS_DEFS_SVH

// Status register field positions
`define TT_LSB 0
`define TT_MSB 2
`define UEN_BIT 3
`define UF_BIT 4
`define IEN_BIT 5
`define IF_BIT 6
`define RM_LSB 7
`define RM_MSB 8
`define SWF_LSB 9
`define SWF_MSB 15
`define RSVD_LSB 16
`define RSVD_MSB 31
`define STATUS_RESET 32'h0000_0000
`define STATUS_WR_MASK 32'h0000_FFFF

// Trap type codes
`define TT_NONE 3'h0
`define TT_UNDERFLOW 3'h1
`define TT_OVERFLOW 3'h2
`define TT_DIVZERO 3'h3
`define TT_ILLEGAL 3'h4
`define TT_INVALID 3'h5
`define TT_INEXACT 3'h6

// Rounding mode codes
`define RM_NEAREST 2'h0
`define RM_ZERO 2'h1
`define RM_POS_INF 2'h2
`define RM_NEG_INF 2'h3

// Integer lengths
`define ISZ_BYTE 2'h0
`define ISZ_WORD 2'h1
`define ISZ_DWORD 2'h2

// Illegal instruction forms: low byte and bits 13..10
`define ILL_LOW_BYTE 8'hBE
`define ILL_FORM_A 4'h3
`define ILL_FORM_B 4'h9

// Floating formats
`define SP_BIAS 12'h07F
`define DP_BIAS 12'h3FF

`endif

// ==== include/fp_status_pkg.sv ====
// Types used by the status block; its register file defines its own
`include "fp_status_defs.svh"
package fp_status_pkg;

    typedef enum logic [2:0] {
        TRAP_NONE = `TT_NONE,
        TRAP_UNDERFLOW = `TT_UNDERFLOW,
        TRAP_OVERFLOW = `TT_OVERFLOW,
        TRAP_DIVZERO = `TT_DIVZERO,
        TRAP_ILLEGAL = `TT_ILLEGAL,
        TRAP_INVALID = `TT_INVALID,
        TRAP_INEXACT = `TT_INEXACT
    } trap_code_t;

    typedef enum logic [1:0] {
        ROUND_NEAREST = `RM_NEAREST,
        ROUND_ZERO = `RM_ZERO,
        ROUND_POS_INF = `RM_POS_INF,
        ROUND_NEG_INF = `RM_NEG_INF
    } round_mode_t;

    typedef struct packed {
        logic [6:0] software_field;
        logic [1:0] rounding_mode;
        logic inexact_flag;
        logic inexact_trap_en;
        logic underflow_flag;
        logic underflow_trap_en;
        logic [2:0] trap_type;
    } status_t;

    typedef struct packed {
        status_t status;
        logic trap_req;
        logic force_zero;
        logic op_done;
        logic round_up;
        logic [31:0] int_ext;
        logic signed [11:0] exp_true;
        logic cpu_xfer;
        logic fp_reg_hit;
    } core_state_t;

endpackage

// ==== core/fp_regfile.sv ====
// Floating-point operand registers with pair access and registered read data
`timescale 1ns/10ps
`default_nettype none
module fp_regfile #(
    parameter int DEPTH = 8,
    parameter int WIDTH = 32,
    parameter int AW = 3
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic srst,
    input wire logic ce,
    // Read port
    input wire logic rd_en,
    input wire logic [AW-1:0] rd_addr,
    input wire logic rd_pair,
    output logic [2*WIDTH-1:0] rd_data_r,
    // Write port
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic wr_pair,
    input wire logic [2*WIDTH-1:0] wr_data
);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [2*WIDTH-1:0] rd_data;
    } rf_state_t;

    rf_state_t st_r;
    rf_state_t st_nxt;

    generate
        if (DEPTH != (1 << AW) || DEPTH < 2) begin : g_bad_depth
            $error("fp_regfile depth must be a power of two matching AW");
        end
    endgenerate

    // Even register holds the low half, the next one the high half
    function automatic logic [AW-1:0] even_of(input logic [AW-1:0] a);
        return {a[AW-1:1], 1'b0};
    endfunction

    always_comb begin
        st_nxt = st_r;
        if (wr_en) begin
            if (wr_pair) begin
                st_nxt.mem[even_of(wr_addr)] = wr_data[WIDTH-1:0];
                st_nxt.mem[even_of(wr_addr) | AW'(1)] = wr_data[2*WIDTH-1:WIDTH];
            end else begin
                st_nxt.mem[wr_addr] = wr_data[WIDTH-1:0];
            end
        end
        if (rd_en) begin
            if (rd_pair) begin
                st_nxt.rd_data = {st_r.mem[even_of(rd_addr) | AW'(1)],
                                  st_r.mem[even_of(rd_addr)]};
            end else begin
                st_nxt.rd_data = {{WIDTH{1'b0}}, st_r.mem[rd_addr]};
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            st_r <= '0;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign rd_data_r = st_r.rd_data;
endmodule // fp_regfile
`default_nettype wire

// ==== core/fp_status_unit.sv ====
// Status, rounding and exception recording of the floating-point coprocessor
// What this block does
// - Integers two's complement, byte word dword
// - Eight 32-bit floating operand registers
// - Double pair: even low, odd high
// - Integer register operand goes via CPU
// - Two-bit rounding mode at bits 7-8
// - Nearest ties round to even
// - Underflow traps if enabled, else zero
// - Inexact traps if enabled, else rounded
// - Clean completion loads trap type zero
// - Trap type cleared by reset, written by load
// - Underflow always recorded, inexact only alone
// - Overflow records code 010
// - Nonzero by zero records code 011
// - Two illegal encodings record code 100
// - Reserved operand or zero/zero: 101
// - Other exception beats inexact, flag kept
// - Underflow flag sticky, cleared by load
// - Inexact flag sticky, only without errors
// - Software field stored, no side effect
// - Reserved operand invalid unless plain move
// - Exponent bias 127 single, 1023 double
`timescale 1ns/10ps
`default_nettype none
`include "fp_status_defs.svh"
module fp_status_unit
    import fp_status_pkg::*;
#(
    parameter int FP_REGS = 8,
    parameter int FP_WIDTH = 32
) (
    // Clock, reset, enable
    input wire logic core_clk,
    input wire logic srst,
    input wire logic ce,
    // Status register load and store
    input wire logic ld_status_valid,
    input wire logic [31:0] ld_status_data,
    output logic [31:0] status_reg_r,
    // Instruction completion
    input wire logic op_valid,
    input wire logic [23:0] op_instr,
    input wire logic op_double,
    input wire logic op_is_divide,
    input wire logic op_is_move,
    input wire logic [63:0] op_a,
    input wire logic [63:0] op_b,
    input wire logic res_overflow,
    input wire logic res_underflow,
    input wire logic res_inexact,
    output logic op_done_r,
    output logic trap_req_r,
    output logic force_zero_r,
    output logic signed [11:0] exp_true_r,
    // Rounding decision
    input wire logic rnd_valid,
    input wire logic rnd_sign,
    input wire logic rnd_lsb,
    input wire logic rnd_guard,
    input wire logic rnd_sticky,
    output logic round_up_r,
    // Integer operand widening
    input wire logic [31:0] int_in,
    input wire logic [1:0] int_size,
    output logic [31:0] int_ext_r,
    // Operand addressing and register file
    input wire logic opd_valid,
    input wire logic [4:0] opd_gen,
    input wire logic opd_is_float,
    input wire logic opd_double,
    input wire logic opd_write,
    input wire logic [63:0] opd_wr_data,
    output logic cpu_xfer_r,
    output logic fp_reg_hit_r,
    output logic [63:0] rd_data_r
);
    localparam int AW = $clog2(FP_REGS);

    generate
        if (FP_REGS != 8 || FP_WIDTH != 32) begin : g_bad_cfg
            $error("fp_status_unit serves eight 32-bit registers only");
        end
    endgenerate

    core_state_t st_r;
    core_state_t st_nxt;

    // Reserved: exponent all ones, or all zeros with nonzero fraction
    function automatic logic is_reserved(input logic [63:0] v, input logic dbl);
        logic [10:0] e;
        logic [51:0] f;
        e = dbl ? v[62:52] : {3'h0, v[30:23]};
        f = dbl ? v[51:0] : {29'h0, v[22:0]};
        if (dbl) begin
            return (e == 11'h7FF) || (e == 11'h000 && f != 52'h0);
        end
        return (e == 11'h0FF) || (e == 11'h000 && f != 52'h0);
    endfunction

    function automatic logic is_zero(input logic [63:0] v, input logic dbl);
        return dbl ? (v[62:0] == 63'h0) : (v[30:0] == 31'h0);
    endfunction

    // Increment decision for one result, per mode
    function automatic logic round_inc(input logic [1:0] mode, input logic sgn,
                                       input logic lsb, input logic g, input logic s);
        case (mode)
            `RM_NEAREST: return g & (s | lsb);
            `RM_ZERO: return 1'b0;
            `RM_POS_INF: return ~sgn & (g | s);
            `RM_NEG_INF: return sgn & (g | s);
            default: return 1'b0;
        endcase
    endfunction

    // Register mode when the top two gen bits are zero
    logic reg_mode;
    logic illegal;
    logic invalid;
    logic divzero;
    logic other_exc;
    logic [2:0] code;
    logic [10:0] raw_exp;

    assign reg_mode = (opd_gen[4:3] == 2'b00);
    assign illegal = (op_instr[7:0] == `ILL_LOW_BYTE) &&
                     (op_instr[13:10] == `ILL_FORM_A || op_instr[13:10] == `ILL_FORM_B);
    assign invalid = (!op_is_move && (is_reserved(op_a, op_double) ||
                      is_reserved(op_b, op_double))) ||
                     (op_is_divide && is_zero(op_a, op_double) &&
                      is_zero(op_b, op_double));
    assign divzero = op_is_divide && is_zero(op_b, op_double) &&
                     !is_zero(op_a, op_double);
    assign other_exc = illegal | invalid | divzero | res_overflow | res_underflow;
    assign raw_exp = op_double ? op_a[62:52] : {3'h0, op_a[30:23]};

    // Worst exception wins the code; inexact only when nothing else
    always_comb begin
        if (illegal) begin
            code = `TT_ILLEGAL;
        end else if (invalid) begin
            code = `TT_INVALID;
        end else if (divzero) begin
            code = `TT_DIVZERO;
        end else if (res_overflow) begin
            code = `TT_OVERFLOW;
        end else if (res_underflow) begin
            code = `TT_UNDERFLOW;
        end else if (res_inexact) begin
            code = `TT_INEXACT;
        end else begin
            code = `TT_NONE;
        end
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.trap_req = 1'b0;
        st_nxt.force_zero = 1'b0;
        st_nxt.op_done = 1'b0;
        // Load first, so a completing op in the same cycle still sets flags
        if (ld_status_valid) begin
            st_nxt.status = status_t'(ld_status_data[`SWF_MSB:0]);
        end
        if (op_valid) begin
            st_nxt.op_done = 1'b1;
            st_nxt.status.trap_type = code;
            if (res_underflow) begin
                st_nxt.status.underflow_flag = 1'b1;
            end
            if (res_inexact && !other_exc) begin
                st_nxt.status.inexact_flag = 1'b1;
            end
            st_nxt.trap_req = illegal | invalid | divzero | res_overflow |
                              (res_underflow & st_r.status.underflow_trap_en) |
                              (res_inexact & !other_exc &
                               st_r.status.inexact_trap_en);
            st_nxt.force_zero = res_underflow & !st_r.status.underflow_trap_en;
            st_nxt.exp_true = $signed({1'b0, raw_exp}) -
                              $signed(op_double ? `DP_BIAS : `SP_BIAS);
        end
        if (rnd_valid) begin
            st_nxt.round_up = round_inc(st_r.status.rounding_mode, rnd_sign, rnd_lsb,
                                        rnd_guard, rnd_sticky);
        end
        case (int_size)
            `ISZ_BYTE: st_nxt.int_ext = {{24{int_in[7]}}, int_in[7:0]};
            `ISZ_WORD: st_nxt.int_ext = {{16{int_in[15]}}, int_in[15:0]};
            default: st_nxt.int_ext = int_in;
        endcase
        if (opd_valid) begin
            st_nxt.fp_reg_hit = reg_mode & opd_is_float;
            st_nxt.cpu_xfer = reg_mode & !opd_is_float;
        end else begin
            st_nxt.fp_reg_hit = 1'b0;
            st_nxt.cpu_xfer = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            st_r <= '0;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    // Integer register operands never touch the local registers
    fp_regfile #(
        .DEPTH(FP_REGS),
        .WIDTH(FP_WIDTH),
        .AW(AW)
    ) u_regs (
        .core_clk(core_clk),
        .srst(srst),
        .ce(ce),
        .rd_en(opd_valid & reg_mode & opd_is_float & !opd_write),
        .rd_addr(opd_gen[AW-1:0]),
        .rd_pair(opd_double),
        .rd_data_r(rd_data_r),
        .wr_en(opd_valid & reg_mode & opd_is_float & opd_write),
        .wr_addr(opd_gen[AW-1:0]),
        .wr_pair(opd_double),
        .wr_data(opd_wr_data)
    );

    assign status_reg_r = {16'h0000, st_r.status};
    assign op_done_r = st_r.op_done;
    assign trap_req_r = st_r.trap_req;
    assign force_zero_r = st_r.force_zero;
    assign exp_true_r = st_r.exp_true;
    assign round_up_r = st_r.round_up;
    assign int_ext_r = st_r.int_ext;
    assign cpu_xfer_r = st_r.cpu_xfer;
    assign fp_reg_hit_r = st_r.fp_reg_hit;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    a_clean_zero: assert property (ce && op_valid && !illegal && !invalid && !divzero
        && !res_overflow && !res_underflow && !res_inexact
        |=> status_reg_r[`TT_MSB:`TT_LSB] == `TT_NONE)
        else $error("clean completion left nonzero trap type");
    a_ovf_code: assert property (ce && op_valid && res_overflow && !illegal && !invalid
        && !divzero |=> status_reg_r[2:0] == 3'h2 && trap_req_r)
        else $error("overflow not recorded as 010 with trap");
    // Illegal form outranks invalid, so it is excluded here
    a_div_zero: assert property (ce && op_valid && op_is_divide && !op_double && !illegal
        && op_a[30:0] == 31'h0 && op_b[30:0] == 31'h0 |=> status_reg_r[2:0] == 3'h5)
        else $error("zero by zero not invalid");
    a_divzero_code: assert property (ce && op_valid && divzero && !illegal && !invalid
        |=> status_reg_r[2:0] == `TT_DIVZERO && trap_req_r)
        else $error("divide by zero not recorded as 011 with trap");
    a_rsvd_trap: assert property (ce && op_valid && !op_is_move && !illegal
        && is_reserved(op_a, op_double)
        |=> status_reg_r[2:0] == `TT_INVALID && trap_req_r)
        else $error("reserved operand not trapped as invalid");
    a_uf_enabled: assert property (ce && op_valid && res_underflow && status_reg_r[`UEN_BIT]
        |=> status_reg_r[`UF_BIT] && trap_req_r && !force_zero_r)
        else $error("enabled underflow not trapped");
    a_illegal_code: assert property (ce && op_valid && op_instr[7:0] == 8'hBE
        && op_instr[13:10] == 4'h9 |=> status_reg_r[2:0] == 3'h4 && trap_req_r)
        else $error("illegal form not caught");
    a_uf_masked: assert property (ce && op_valid && res_underflow
        && !status_reg_r[`UEN_BIT] && !illegal && !invalid && !divzero && !res_overflow
        |=> force_zero_r && !trap_req_r && status_reg_r[`UF_BIT]
            && status_reg_r[2:0] == 3'h1)
        else $error("masked underflow handled wrongly");
    a_uf_sticky: assert property (status_reg_r[`UF_BIT] && !(ce && ld_status_valid)
        |=> status_reg_r[`UF_BIT])
        else $error("underflow flag dropped without load");
    a_if_kept: assert property (ce && op_valid && res_inexact && res_overflow
        && !ld_status_valid |=> status_reg_r[`IF_BIT] == $past(status_reg_r[`IF_BIT])
            && status_reg_r[2:0] != 3'h6)
        else $error("inexact overrode another exception");
    a_inexact_trap: assert property (ce && op_valid && res_inexact && !other_exc
        |=> trap_req_r == $past(status_reg_r[`IEN_BIT]) && status_reg_r[`IF_BIT])
        else $error("inexact trap gating wrong");
    a_rsvd_zero: assert property (status_reg_r[`RSVD_MSB:`RSVD_LSB] == 16'h0)
        else $error("reserved status bits nonzero");
    a_swf_load: assert property (ce && ld_status_valid && !op_valid
        |=> status_reg_r[`SWF_MSB:`SWF_LSB] == $past(ld_status_data[`SWF_MSB:`SWF_LSB])
            ##1 (ce && !ld_status_valid)[*1] |=> $stable(status_reg_r[`SWF_MSB:`SWF_LSB]))
        else $error("software field not held");
    a_tie_even: assert property (ce && rnd_valid && status_reg_r[8:7] == 2'b00 && rnd_guard
        && !rnd_sticky |=> round_up_r == $past(rnd_lsb))
        else $error("tie not rounded to even");
    a_int_xfer: assert property (ce && opd_valid && opd_gen[4:3] == 2'b00 && !opd_is_float
        |=> cpu_xfer_r && !fp_reg_hit_r)
        else $error("integer register operand used locally");

    c_uf_trap: cover property (ce && op_valid && res_underflow && status_reg_r[`UEN_BIT]);
    c_pair_read: cover property (ce && opd_valid && opd_double && opd_is_float
        && opd_gen[4:3] == 2'b00 && !opd_write);
    c_load_and_op: cover property (ce && ld_status_valid && op_valid);
    c_divzero: cover property (ce && op_valid && divzero);
endmodule // fp_status_unit
`default_nettype wire

// ==== verif/host_cpu_model.sv ====
// Host side model that supplies integer operands to the status block
`timescale 1ns/10ps
`default_nettype none
module host_cpu_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // Integer operand towards the coprocessor
    output logic [31:0] int_in,
    output logic [1:0] int_size
);
    integer seed = 32'h37D2;
    initial begin
        int_in = 32'h0;
        int_size = 2'h0;
        forever begin
            @(posedge core_clk);
            #1;
            // Any length code, top code included, so dword aliasing is hit
            int_in = srst ? 32'h0 : $random(seed);
            int_size = $random(seed);
        end
    end
endmodule // host_cpu_model
`default_nettype wire

// ==== verif/fp_status_unit_tb.sv ====
// Self-checking bench for the status and exception block
`timescale 1ns/10ps
`default_nettype none
module fp_status_unit_tb;
    logic core_clk, srst, ce, ld_status_valid, op_valid, op_double, op_is_divide, op_is_move;
    logic res_overflow, res_underflow, res_inexact, op_done_r, trap_req_r, force_zero_r;
    logic rnd_valid, rnd_sign, rnd_lsb, rnd_guard, rnd_sticky, round_up_r;
    logic opd_valid, opd_is_float, opd_double, opd_write, cpu_xfer_r, fp_reg_hit_r;
    logic [31:0] ld_status_data, status_reg_r, int_in, int_ext_r;
    logic [23:0] op_instr;
    logic [63:0] op_a, op_b, opd_wr_data, rd_data_r;
    logic signed [11:0] exp_true_r;
    logic [1:0] int_size;
    logic [4:0] opd_gen;
    integer seed = 32'h37D2;
    int bad_count = 0;
    int num_checks = 0;
    logic [63:0] exp_q[$];
    logic [63:0] got, erd;
    logic [31:0] rf[8];
    logic [31:0] r, p_in;
    logic [15:0] s;
    logic [11:0] ex;
    logic [2:0] tt, pr;
    logic [1:0] p_sz;
    logic was_ld, was_rnd, er, eh, ex2, rd_chk, reg_md, za, zb, inv, tr, fz;

    fp_status_unit u_dut (.core_clk, .srst, .ce, .ld_status_valid, .ld_status_data,
        .status_reg_r, .op_valid, .op_instr, .op_double, .op_is_divide, .op_is_move,
        .op_a, .op_b, .res_overflow, .res_underflow, .res_inexact, .op_done_r, .trap_req_r,
        .force_zero_r, .exp_true_r, .rnd_valid, .rnd_sign, .rnd_lsb, .rnd_guard,
        .rnd_sticky, .round_up_r, .int_in, .int_size, .int_ext_r, .opd_valid, .opd_gen,
        .opd_is_float, .opd_double, .opd_write, .opd_wr_data, .cpu_xfer_r, .fp_reg_hit_r,
        .rd_data_r);

    host_cpu_model u_host (.core_clk, .srst, .int_in, .int_size);

    task automatic chk(input logic [63:0] seen, input logic [63:0] want);
        num_checks++;
        if (seen !== want) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Operand picks in both formats: zero, one, infinity, denormal; the last two are reserved
    function automatic logic [63:0] opv(input logic [1:0] k);
        case (k)
            2'h0: return 64'h0;
            2'h1: return 64'h3FF0_0000_3F80_0000;
            2'h2: return 64'h7FF0_0000_7F80_0000;
            default: return 64'h1;
        endcase
    endfunction

    function automatic logic rsv(input logic [63:0] x, input logic d);
        if (d) return &x[62:52] || (x[62:52] == 11'h0 && x[51:0] != 52'h0);
        return &x[30:23] || (x[30:23] == 8'h0 && x[22:0] != 23'h0);
    endfunction

    function automatic logic zr(input logic [63:0] x, input logic d);
        return d ? (x[62:0] == 63'h0) : (x[30:0] == 31'h0);
    endfunction

    function automatic logic [31:0] sext(input logic [31:0] x, input logic [1:0] z);
        if (z == 2'h0) return {{24{x[7]}}, x[7:0]};
        if (z == 2'h1) return {{16{x[15]}}, x[15:0]};
        return x;
    endfunction

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // Results arrive as one-cycle pulses; the oldest note belongs to them
    always @(negedge core_clk) begin
        if (op_done_r === 1'b1) begin
            got = {18'h0, exp_true_r, trap_req_r, force_zero_r, status_reg_r};
            if (exp_q.size() == 0) begin
                chk(got, 64'h0);
            end else begin
                chk(got, exp_q.pop_front());
            end
        end
    end

    initial begin
        #60000;
        bad_count++;
        close_out();
    end

    initial begin
        {srst, ce} = 2'b11;
        {ld_status_valid, op_valid, op_double, op_is_divide, op_is_move} = 5'h0;
        {res_overflow, res_underflow, res_inexact, rnd_valid} = 4'h0;
        {rnd_sign, rnd_lsb, rnd_guard, rnd_sticky} = 4'h0;
        {opd_valid, opd_is_float, opd_double, opd_write} = 4'h0;
        {ld_status_data, op_instr, opd_gen} = 61'h0;
        {op_a, op_b, opd_wr_data} = 192'h0;
        s = 16'h0;
        foreach (rf[i]) rf[i] = 32'h0;
        repeat (3) @(posedge core_clk);
        #1;
        srst = 1'b0;
        chk(status_reg_r, 64'h0);
        for (int i = 0; i < 2000; i++) begin
            r = $random(seed);
            ld_status_valid = (r[2:0] == 3'h0);
            ld_status_data = $random(seed);
            op_valid = !ld_status_valid && r[3];
            op_double = r[4];
            op_is_divide = r[5];
            op_is_move = r[6] & r[7];
            res_overflow = r[8] & r[9];
            res_underflow = r[10] & r[11];
            res_inexact = r[12];
            op_a = opv(r[14:13]);
            op_b = opv(r[16:15]);
            op_instr = $random(seed);
            if (r[17] & r[18]) begin
                op_instr[7:0] = 8'hBE;
                op_instr[13:10] = r[19] ? 4'h3 : 4'h9;
            end
            rnd_valid = r[20];
            {rnd_sign, rnd_lsb, rnd_guard, rnd_sticky} = r[24:21];
            opd_valid = r[25];
            opd_gen = $random(seed);
            if (r[26]) opd_gen[4:3] = 2'h0;
            {opd_is_float, opd_double, opd_write} = r[29:27];
            opd_wr_data = {$random(seed), $random(seed)};
            was_ld = ld_status_valid;
            was_rnd = rnd_valid;
            case (s[8:7])
                2'h0: er = rnd_guard & (rnd_sticky | rnd_lsb);
                2'h1: er = 1'b0;
                2'h2: er = !rnd_sign & (rnd_guard | rnd_sticky);
                default: er = rnd_sign & (rnd_guard | rnd_sticky);
            endcase
            if (ld_status_valid) s = ld_status_data[15:0];
            if (op_valid) begin
                za = zr(op_a, op_double);
                zb = zr(op_b, op_double);
                inv = (!op_is_move && (rsv(op_a, op_double) || rsv(op_b, op_double)))
                    || (op_is_divide && za && zb);
                tt = (op_instr[7:0] == 8'hBE && op_instr[13:10] inside {4'h3, 4'h9}) ? 3'h4
                    : inv ? 3'h5 : (op_is_divide && zb) ? 3'h3 : res_overflow ? 3'h2
                    : res_underflow ? 3'h1 : res_inexact ? 3'h6 : 3'h0;
                tr = (tt inside {3'h2, 3'h3, 3'h4, 3'h5}) || (res_underflow && s[3])
                    || (tt == 3'h6 && s[5]);
                fz = res_underflow && !s[3];
                ex = op_double ? {1'b0, op_a[62:52]} - 12'h3FF
                    : {4'h0, op_a[30:23]} - 12'h07F;
                s[2:0] = tt;
                s[4] = s[4] | res_underflow;
                s[6] = s[6] | (tt == 3'h6);
                exp_q.push_back({18'h0, ex, tr, fz, 16'h0, s});
            end
            reg_md = opd_valid && opd_gen[4:3] == 2'h0;
            eh = reg_md && opd_is_float;
            ex2 = reg_md && !opd_is_float;
            pr = {opd_gen[2:1], 1'b0};
            rd_chk = eh && !opd_write;
            if (rd_chk) erd = opd_double ? {rf[pr+1], rf[pr]} : {32'h0, rf[opd_gen[2:0]]};
            if (eh && opd_write && opd_double) begin
                rf[pr] = opd_wr_data[31:0];
                rf[pr+1] = opd_wr_data[63:32];
            end else if (eh && opd_write) begin
                rf[opd_gen[2:0]] = opd_wr_data[31:0];
            end
            @(negedge core_clk);
            p_in = int_in;
            p_sz = int_size;
            @(posedge core_clk);
            #1;
            if (was_ld) chk(status_reg_r, {16'h0, s});
            if (was_rnd) chk(round_up_r, er);
            chk(int_ext_r, sext(p_in, p_sz));
            chk({fp_reg_hit_r, cpu_xfer_r}, {eh, ex2});
            if (rd_chk) chk(rd_data_r, erd);
        end
        {ld_status_valid, op_valid, rnd_valid, opd_valid} = 4'h0;
        repeat (3) @(posedge core_clk);
        #1;
        // Enable low must freeze everything, even a completing op
        ce = 1'b0;
        op_valid = 1'b1;
        res_overflow = 1'b1;
        @(posedge core_clk);
        #1;
        chk(op_done_r, 1'b0);
        chk(status_reg_r, {16'h0, s});
        ce = 1'b1;
        op_valid = 1'b0;
        res_overflow = 1'b0;
        // Mid-run reset clears whatever the random loads left behind
        srst = 1'b1;
        @(posedge core_clk);
        #1;
        srst = 1'b0;
        chk(status_reg_r, 64'h0);
        @(posedge core_clk);
        #1;
        chk(status_reg_r, 64'h0);
        chk(exp_q.size(), 0);
        close_out();
    end
endmodule // fp_status_unit_tb
`default_nettype wire
